// ---- hdl/ddrca_pkg.sv ----
// shared constants, types and helpers of the ddr command/address front end
package ddrca_pkg;

	// ==========================================================
	// widths
	localparam int ADDR_W = 12;
	localparam int ROW_W = 12;
	localparam int COL_W = 9;
	localparam int BANK_W = 2;
	localparam int NBANK = 4;
	localparam int DQ_W = 16;
	localparam int LANES = 2;
	localparam int AP_BIT = 10;

	// ==========================================================
	// mode register fields and encodings
	localparam int MR_BL_LSB = 0;
	localparam int MR_BT_BIT = 3;
	localparam int MR_CL_LSB = 4;
	localparam logic [2:0] BL_CODE_2 = 3'h1;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;
	localparam logic [2:0] CL_CODE_2 = 3'h2;
	localparam logic [2:0] CL_CODE_25 = 3'h6;
	localparam logic [2:0] CL_CODE_3 = 3'h3;
	localparam logic [1:0] MR_SEL_BASE = 2'h0;
	localparam logic [1:0] MR_SEL_EXT = 2'h1;
	localparam logic [11:0] MODE_RST = 12'h000;

	// ==========================================================
	// refresh timing
	localparam int REF_WINDOW_MS = 64;
	localparam int REF_CYCLES = 4096;
	localparam int CORE_CLK_MHZ = 200;
	// longest spacing, rounded down
	localparam int REF_INTERVAL_CYC = (REF_WINDOW_MS * 1000 * CORE_CLK_MHZ) / REF_CYCLES;
	localparam logic [11:0] REF_LAST = 12'(REF_INTERVAL_CYC - 1);

	// ==========================================================
	// command codes as {row strobe, column strobe, write enable}
	localparam logic [2:0] CMD_MODE = 3'h0;
	localparam logic [2:0] CMD_REFRESH = 3'h1;
	localparam logic [2:0] CMD_PRECHARGE = 3'h2;
	localparam logic [2:0] CMD_ACTIVATE = 3'h3;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_BURST_STOP = 3'h6;

	typedef enum logic [3:0] {
		PWR_ACTIVE = 4'h1,
		PWR_PD_PRE = 4'h2,
		PWR_PD_ACT = 4'h4,
		PWR_SELF = 4'h8
	} ddrca_pwr_type;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [BANK_W-1:0] ba;
		logic [ADDR_W-1:0] addr;
	} ddrca_cmd_type;

	// index 0 is the rising-edge half, index 1 the falling-edge half
	typedef struct packed {
		logic [1:0][DQ_W-1:0] dq;
		logic [1:0][LANES-1:0] dm;
		logic [1:0][LANES-1:0] dqs;
	} ddrca_beat_type;

	typedef struct packed {
		ddrca_cmd_type cmd;
		ddrca_beat_type beat;
	} ddrca_pkt_type;

	typedef struct packed {
		logic valid;
		logic [BANK_W-1:0] ba;
		logic [ROW_W-1:0] row;
		logic [1:0][COL_W-1:0] col;
		logic [2*DQ_W-1:0] data;
		logic [3:0] byte_en;
	} ddrca_wr_type;

	typedef struct packed {
		logic valid;
		logic [BANK_W-1:0] ba;
		logic [ROW_W-1:0] row;
		logic [1:0][COL_W-1:0] col;
	} ddrca_rd_type;

	// ==========================================================
	// helpers
	function automatic logic [2:0] ddrca_bl_pairs(input logic [2:0] code);
		case (code)
			BL_CODE_2: return 3'h1;
			BL_CODE_4: return 3'h2;
			BL_CODE_8: return 3'h4;
			default: return 3'h0;
		endcase
	endfunction

	function automatic logic [COL_W-1:0] ddrca_burst_col(input logic [COL_W-1:0] base,
		input logic [2:0] idx, input logic [2:0] code, input logic interleave);
		logic [2:0] m;
		logic [2:0] off;
		case (code)
			BL_CODE_2: m = 3'h1;
			BL_CODE_4: m = 3'h3;
			default: m = 3'h7;
		endcase
		off = interleave ? (base[2:0] ^ idx) : 3'(base[2:0] + idx);
		return {base[COL_W-1:3], (base[2:0] & ~m) | (off & m)};
	endfunction

endpackage

// ---- hdl/ddrca_link_io.sv ----
// link-clock capture and double-rate launch stage of the ddr front end
`timescale 1ns/1ps
`default_nettype none
module ddrca_link_io (
	// link clock and core reset
	input wire logic link_clk_i,
	input wire logic srst_i,
	// pins
	input wire ddrca_pkg::ddrca_cmd_type cmd_i,
	input wire logic [15:0] dq_i,
	input wire logic [1:0] dm_i,
	input wire logic [1:0] dqs_i,
	output logic [15:0] dq_o,
	output logic dq_oe_o,
	output logic dqs_o,
	// toward core
	output ddrca_pkg::ddrca_pkt_type pkt_o,
	output logic pkt_tog_o,
	input wire logic [31:0] rd_word_i,
	input wire logic rd_tog_i
);
	import ddrca_pkg::*;

	logic [1:0] rst_sync_r;
	logic [2:0] rd_sync_r;
	logic [15:0] rise_dq_r;
	logic [1:0] rise_dm_r;
	logic [1:0] rise_dqs_r;
	logic [15:0] fall_dq_r;
	logic [1:0] fall_dm_r;
	logic [1:0] fall_dqs_r;
	logic [15:0] hi_r;
	logic [15:0] dq_p_r;
	logic [15:0] dq_n_r;
	logic dqs_p_r;
	logic dqs_n_r;
	logic link_rst;
	logic load;

	assign link_rst = rst_sync_r[1];
	// output disable follows clock gating on the next rising edge
	assign load = (rd_sync_r[1] ^ rd_sync_r[2]) & cmd_i.cke;

	// ==========================================================
	// rising edge: command capture and first data half
	always_ff @(posedge link_clk_i) begin
		rst_sync_r <= {rst_sync_r[0], srst_i};
		if (link_rst) begin
			rd_sync_r <= 3'h0;
			rise_dq_r <= 16'h0000;
			rise_dm_r <= 2'h0;
			rise_dqs_r <= 2'h0;
			pkt_o <= '0;
			pkt_tog_o <= 1'b0;
			hi_r <= 16'h0000;
			dq_p_r <= 16'h0000;
			dq_oe_o <= 1'b0;
			dqs_p_r <= 1'b0;
		end else begin
			rd_sync_r <= {rd_sync_r[1:0], rd_tog_i};
			rise_dq_r <= dq_i;
			rise_dm_r <= dm_i;
			rise_dqs_r <= dqs_i;
			pkt_o.cmd <= cmd_i;
			pkt_o.beat.dq <= {fall_dq_r, rise_dq_r};
			pkt_o.beat.dm <= {fall_dm_r, rise_dm_r};
			pkt_o.beat.dqs <= {fall_dqs_r, rise_dqs_r};
			pkt_tog_o <= ~pkt_tog_o;
			if (load) begin
				// xor pairing lets each half own its flop
				dq_p_r <= rd_word_i[15:0] ^ dq_n_r;
				hi_r <= rd_word_i[31:16];
				dq_oe_o <= 1'b1;
				dqs_p_r <= ~dqs_n_r;
			end else begin
				dq_p_r <= dq_n_r;
				dq_oe_o <= 1'b0;
				dqs_p_r <= dqs_n_r;
			end
		end
	end

	// ==========================================================
	// falling edge: second data half
	always_ff @(negedge link_clk_i) begin
		if (link_rst) begin
			fall_dq_r <= 16'h0000;
			fall_dm_r <= 2'h0;
			fall_dqs_r <= 2'h0;
			dq_n_r <= 16'h0000;
			dqs_n_r <= 1'b0;
		end else begin
			fall_dq_r <= dq_i;
			fall_dm_r <= dm_i;
			fall_dqs_r <= dqs_i;
			dq_n_r <= dq_oe_o ? (hi_r ^ dq_p_r) : dq_p_r;
			dqs_n_r <= dqs_p_r;
		end
	end

	assign dq_o = dq_p_r ^ dq_n_r;
	assign dqs_o = dqs_p_r ^ dqs_n_r;

endmodule
`default_nettype wire

// ---- hdl/ddrca_cmd_addr_if.sv ----
// command decode, bank, mode and power state of the ddr front end
`timescale 1ns/1ps
`default_nettype none

module ddrca_cmd_addr_if (
	// core clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// link clock and command pins
	input wire logic diff_clock_true_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic bank_sel_0_i,
	input wire logic bank_sel_1_i,
	input wire logic [11:0] addr_in_i,
	// data pins
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o,
	output logic dq_oe_o,
	input wire logic [1:0] write_mask_i,
	input wire logic lower_lane_strobe_i,
	output logic lower_lane_strobe_o,
	output logic lower_lane_strobe_oe_o,
	input wire logic upper_lane_strobe_i,
	output logic upper_lane_strobe_o,
	output logic upper_lane_strobe_oe_o,
	// array side
	output ddrca_pkg::ddrca_wr_type wr_o,
	output ddrca_pkg::ddrca_rd_type rd_o,
	input wire logic [31:0] rd_data_i,
	output logic refresh_o,
	// status
	output logic [3:0] bank_open_o,
	output ddrca_pkg::ddrca_pwr_type power_state_o,
	output logic [11:0] base_mode_o,
	output logic [11:0] ext_mode_o
);
	import ddrca_pkg::*;

	typedef struct packed {
		logic [2:0] tog_sync;
		logic [1:0] cke_sync;
		logic pkt_cke;
		logic [11:0] mode_base;
		logic [11:0] mode_ext;
		logic [3:0] bank_open;
		logic [3:0][11:0] bank_row;
		ddrca_pwr_type pwr;
		logic wr_wait;
		logic [2:0] wr_left;
		logic [2:0] wr_idx;
		logic [1:0] wr_ba;
		logic [8:0] wr_base;
		logic wr_ap;
		logic [2:0] rd_left;
		logic [2:0] rd_idx;
		logic [1:0] rd_ba;
		logic [8:0] rd_base;
		logic rd_ap;
		logic [11:0] ref_cnt;
		logic refresh;
		ddrca_wr_type wr;
		ddrca_rd_type rd;
		logic rd_pend;
		logic [31:0] rd_word;
		logic rd_tog;
	} ddrca_core_state_type;

	ddrca_core_state_type s_r;
	ddrca_core_state_type s_nxt;

	ddrca_cmd_type pin_cmd;
	ddrca_pkt_type pkt;
	logic pkt_tog;
	logic dqs_w;
	logic dq_oe_w;
	logic pkt_new;
	logic cmd_ok;
	logic [2:0] code;
	logic [2:0] bl_code;
	logic bt_il;
	logic [2:0] pairs;

	// ==========================================================
	// link stage
	assign pin_cmd.cke = cke_i;
	assign pin_cmd.cs_n = cs_n_i;
	assign pin_cmd.ras_n = ras_n_i;
	assign pin_cmd.cas_n = cas_n_i;
	assign pin_cmd.we_n = we_n_i;
	assign pin_cmd.ba = {bank_sel_1_i, bank_sel_0_i};
	assign pin_cmd.addr = addr_in_i;

	ddrca_link_io u_link (
		.link_clk_i(diff_clock_true_i),
		.srst_i(srst_i),
		.cmd_i(pin_cmd),
		.dq_i(dq_i),
		.dm_i(write_mask_i),
		.dqs_i({upper_lane_strobe_i, lower_lane_strobe_i}),
		.dq_o(dq_o),
		.dq_oe_o(dq_oe_w),
		.dqs_o(dqs_w),
		.pkt_o(pkt),
		.pkt_tog_o(pkt_tog),
		.rd_word_i(s_r.rd_word),
		.rd_tog_i(s_r.rd_tog)
	);

	// both lanes launch together on reads
	assign dq_oe_o = dq_oe_w;
	assign lower_lane_strobe_o = dqs_w;
	assign upper_lane_strobe_o = dqs_w;
	assign lower_lane_strobe_oe_o = dq_oe_w;
	assign upper_lane_strobe_oe_o = dq_oe_w;

	// ==========================================================
	// decode helpers
	// packet bus is held a whole link cycle, far longer than the toggle takes to cross
	assign pkt_new = s_r.tog_sync[1] ^ s_r.tog_sync[2];
	assign cmd_ok = s_r.pkt_cke & ~pkt.cmd.cs_n;
	assign code = {pkt.cmd.ras_n, pkt.cmd.cas_n, pkt.cmd.we_n};
	assign bl_code = s_r.mode_base[MR_BL_LSB +: 3];
	assign bt_il = s_r.mode_base[MR_BT_BIT];
	assign pairs = ddrca_bl_pairs(bl_code);

	// ==========================================================
	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.tog_sync = {s_r.tog_sync[1:0], pkt_tog};
		s_nxt.cke_sync = {s_r.cke_sync[0], cke_i};
		s_nxt.refresh = 1'b0;
		s_nxt.wr.valid = 1'b0;
		s_nxt.rd.valid = 1'b0;
		s_nxt.rd_pend = s_r.rd.valid;
		// array answers one cycle after each read request
		if (s_r.rd_pend) begin
			s_nxt.rd_word = rd_data_i;
			s_nxt.rd_tog = ~s_r.rd_tog;
		end
		if (pkt_new) begin
			s_nxt.pkt_cke = pkt.cmd.cke;
		end
		case (s_r.pwr)
			PWR_ACTIVE: begin
				if (pkt_new) begin
					// bursts advance one word pair per link clock
					if (s_r.wr_left != 3'h0) begin
						if (s_r.wr_wait) begin
							s_nxt.wr_wait = 1'b0;
						end else begin
							s_nxt.wr.valid = 1'b1;
							s_nxt.wr.ba = s_r.wr_ba;
							s_nxt.wr.row = s_r.bank_row[s_r.wr_ba];
							s_nxt.wr.col[0] = ddrca_burst_col(s_r.wr_base, s_r.wr_idx, bl_code, bt_il);
							s_nxt.wr.col[1] = ddrca_burst_col(s_r.wr_base, 3'(s_r.wr_idx + 3'h1),
								bl_code, bt_il);
							s_nxt.wr.data = {pkt.beat.dq[1], pkt.beat.dq[0]};
							s_nxt.wr.byte_en = ~{pkt.beat.dm[1], pkt.beat.dm[0]};
							s_nxt.wr_idx = 3'(s_r.wr_idx + 3'h2);
							s_nxt.wr_left = 3'(s_r.wr_left - 3'h1);
							if (s_r.wr_left == 3'h1 && s_r.wr_ap) begin
								s_nxt.bank_open[s_r.wr_ba] = 1'b0;
							end
						end
					end
					if (s_r.rd_left != 3'h0) begin
						s_nxt.rd.valid = 1'b1;
						s_nxt.rd.ba = s_r.rd_ba;
						s_nxt.rd.row = s_r.bank_row[s_r.rd_ba];
						s_nxt.rd.col[0] = ddrca_burst_col(s_r.rd_base, s_r.rd_idx, bl_code, bt_il);
						s_nxt.rd.col[1] = ddrca_burst_col(s_r.rd_base, 3'(s_r.rd_idx + 3'h1),
							bl_code, bt_il);
						s_nxt.rd_idx = 3'(s_r.rd_idx + 3'h2);
						s_nxt.rd_left = 3'(s_r.rd_left - 3'h1);
						if (s_r.rd_left == 3'h1 && s_r.rd_ap) begin
							s_nxt.bank_open[s_r.rd_ba] = 1'b0;
						end
					end
					if (cmd_ok) begin
						case (code)
							CMD_MODE: begin
								if (pkt.cmd.ba == MR_SEL_BASE) begin
									s_nxt.mode_base = pkt.cmd.addr;
								end else if (pkt.cmd.ba == MR_SEL_EXT) begin
									s_nxt.mode_ext = pkt.cmd.addr;
								end
							end
							CMD_ACTIVATE: begin
								s_nxt.bank_open[pkt.cmd.ba] = 1'b1;
								s_nxt.bank_row[pkt.cmd.ba] = pkt.cmd.addr;
							end
							CMD_PRECHARGE: begin
								if (pkt.cmd.addr[AP_BIT]) begin
									s_nxt.bank_open = 4'h0;
								end else begin
									s_nxt.bank_open[pkt.cmd.ba] = 1'b0;
								end
							end
							CMD_WRITE: begin
								// unsupported burst code leaves the command without effect
								if (s_r.bank_open[pkt.cmd.ba] && pairs != 3'h0) begin
									s_nxt.wr_left = pairs;
									s_nxt.wr_idx = 3'h0;
									s_nxt.wr_wait = 1'b1;
									s_nxt.wr_ba = pkt.cmd.ba;
									s_nxt.wr_base = pkt.cmd.addr[8:0];
									s_nxt.wr_ap = pkt.cmd.addr[AP_BIT];
									s_nxt.rd_left = 3'h0;
								end
							end
							CMD_READ: begin
								if (s_r.bank_open[pkt.cmd.ba] && pairs != 3'h0) begin
									s_nxt.rd_left = pairs;
									s_nxt.rd_idx = 3'h0;
									s_nxt.rd_ba = pkt.cmd.ba;
									s_nxt.rd_base = pkt.cmd.addr[8:0];
									s_nxt.rd_ap = pkt.cmd.addr[AP_BIT];
									s_nxt.wr_left = 3'h0;
								end
							end
							CMD_BURST_STOP: begin
								s_nxt.rd_left = 3'h0;
							end
							CMD_REFRESH: begin
								if (pkt.cmd.cke) begin
									s_nxt.refresh = 1'b1;
								end else if (s_nxt.bank_open == 4'h0) begin
									s_nxt.pwr = PWR_SELF;
									s_nxt.ref_cnt = 12'h000;
									s_nxt.refresh = 1'b1;
								end
							end
							default: begin
							end
						endcase
					end
					// gating falls outside a refresh: power-down
					if (s_r.pkt_cke && !pkt.cmd.cke && s_nxt.pwr == PWR_ACTIVE) begin
						s_nxt.pwr = (s_nxt.bank_open == 4'h0) ? PWR_PD_PRE : PWR_PD_ACT;
						// a burst cut by gating is dropped, not resumed
						s_nxt.wr_left = 3'h0;
						s_nxt.rd_left = 3'h0;
					end
				end
			end
			PWR_PD_PRE, PWR_PD_ACT: begin
				// only the gating level is looked at here
				if (pkt_new && pkt.cmd.cke) begin
					s_nxt.pwr = PWR_ACTIVE;
				end
			end
			PWR_SELF: begin
				s_nxt.ref_cnt = 12'(s_r.ref_cnt + 12'h001);
				if (s_r.ref_cnt == REF_LAST) begin
					s_nxt.ref_cnt = 12'h000;
					s_nxt.refresh = 1'b1;
				end
				// link clock may be stopped, so exit watches the pin itself
				if (s_r.cke_sync[1]) begin
					s_nxt.pwr = PWR_ACTIVE;
				end
			end
			default: begin
				s_nxt.pwr = PWR_ACTIVE;
			end
		endcase
	end

	// ==========================================================
	// state register
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			s_r <= '0;
			s_r.mode_base <= MODE_RST;
			s_r.mode_ext <= MODE_RST;
			s_r.pwr <= PWR_ACTIVE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wr_o = s_r.wr;
	assign rd_o = s_r.rd;
	assign refresh_o = s_r.refresh;
	assign bank_open_o = s_r.bank_open;
	assign power_state_o = s_r.pwr;
	assign base_mode_o = s_r.mode_base;
	assign ext_mode_o = s_r.mode_ext;

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	sequence s_cmd(logic [2:0] k);
		pkt_new && s_r.pwr == PWR_ACTIVE && cmd_ok && code == k;
	endsequence

	sequence s_no_refresh;
		!s_r.refresh [*8];
	endsequence

	a_select_ignore: assert property (pkt_new && pkt.cmd.cs_n && s_r.pwr == PWR_ACTIVE
		&& s_r.wr_left == 3'h0 && s_r.rd_left == 3'h0
		|=> $stable(s_r.bank_open) && $stable(s_r.mode_base) && $stable(s_r.mode_ext))
		else $error("command taken while deselected");

	a_activate_bank: assert property (s_cmd(CMD_ACTIVATE)
		|=> s_r.bank_open[$past(pkt.cmd.ba)] && s_r.bank_row[$past(pkt.cmd.ba)] == $past(pkt.cmd.addr))
		else $error("activate did not open the bank");

	a_precharge_all: assert property (s_cmd(CMD_PRECHARGE) and pkt.cmd.addr[AP_BIT]
		|=> s_r.bank_open == 4'h0)
		else $error("precharge all left a bank open");

	a_precharge_one: assert property (s_cmd(CMD_PRECHARGE) and !pkt.cmd.addr[AP_BIT]
		|=> !s_r.bank_open[$past(pkt.cmd.ba)])
		else $error("single precharge missed its bank");

	a_mode_base: assert property (s_cmd(CMD_MODE) and pkt.cmd.ba == MR_SEL_BASE
		|=> s_r.mode_base == $past(pkt.cmd.addr) && $stable(s_r.mode_ext))
		else $error("base mode load wrong");

	a_pd_entry: assert property (pkt_new && s_r.pwr == PWR_ACTIVE && s_r.pkt_cke
		&& !pkt.cmd.cke && !(cmd_ok && code == CMD_REFRESH)
		|=> s_r.pwr != PWR_ACTIVE && ((s_r.pwr == PWR_PD_PRE) == (s_r.bank_open == 4'h0)))
		else $error("power-down entry wrong");

	a_self_exit: assert property (s_r.pwr == PWR_SELF && s_r.cke_sync[1]
		|=> s_r.pwr == PWR_ACTIVE)
		else $error("self refresh did not exit");

	a_self_period: assert property (s_r.pwr == PWR_SELF && s_r.ref_cnt == REF_LAST
		|=> s_r.refresh ##1 s_no_refresh)
		else $error("self refresh spacing wrong");

	a_write_delay: assert property (s_cmd(CMD_WRITE) and s_r.bank_open[pkt.cmd.ba]
		and pairs != 3'h0 |=> !s_r.wr.valid [*8])
		else $error("write word taken too early");

	a_read_return: assert property (s_r.rd.valid
		|-> ##2 (s_r.rd_tog != $past(s_r.rd_tog)) && s_r.rd_word == $past(rd_data_i))
		else $error("read word not handed to link");

endmodule
`default_nettype wire

// ---- bench/ddrca_ctrl_model.sv ----
// controller-side model: link clock, command, address, data and mask pins
`timescale 1ns/1ps
`default_nettype none
module ddrca_ctrl_model (
	// link clock
	output logic lclk_o,
	// command pins
	output logic cke_o,
	output logic cs_n_o,
	output logic [2:0] cmd_o,
	output logic [1:0] ba_o,
	output logic [11:0] addr_o,
	// write data pins
	output logic [15:0] dq_o,
	output logic [1:0] msk_o,
	output logic qs_o
);
	import ddrca_pkg::*;
	logic [15:0] wd [4];
	logic [1:0] wm [4];
	// ==========================================================
	// clock, free running, phase unrelated to the core clock
	initial begin
		lclk_o = 1'b0;
		#7;
		forever #24 lclk_o = ~lclk_o;
	end
	initial begin
		cke_o = 1'b1;
		cs_n_o = 1'b1;
		cmd_o = 3'h7;
		ba_o = 2'h0;
		addr_o = 12'h000;
		dq_o = 16'h0000;
		msk_o = 2'h0;
		qs_o = 1'b0;
	end
	// ==========================================================
	// one command, then n word pairs of write data
	// bank and address pins go inverted on deselect, data and mask once released, so stale levels never pass
	task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
		input logic sel_n, input logic k, input int n);
		@(posedge lclk_o);
		cke_o <= k;
		cs_n_o <= sel_n;
		cmd_o <= c;
		ba_o <= b;
		addr_o <= a;
		@(posedge lclk_o);
		cs_n_o <= 1'b1;
		ba_o <= ~b;
		addr_o <= ~a;
		for (int i = 0; i < n; i++) begin
			@(negedge lclk_o);
			dq_o <= wd[2*i];
			msk_o <= wm[2*i];
			// strobe edges sit mid-eye, a quarter clock after each data change
			#12 qs_o <= 1'b1;
			@(posedge lclk_o);
			dq_o <= wd[2*i+1];
			msk_o <= wm[2*i+1];
			#12 qs_o <= 1'b0;
		end
		@(negedge lclk_o);
		dq_o <= ~dq_o;
		msk_o <= ~msk_o;
		@(posedge lclk_o);
	endtask
	task automatic hold_cke(input logic k);
		@(posedge lclk_o);
		cke_o <= k;
	endtask
endmodule
`default_nettype wire

// ---- bench/tb_ddr_sdram_cmd_addr_interface.sv ----
// self-checking bench of the ddr command/address front end
`timescale 1ns/1ps
`default_nettype none
module tb_ddr_sdram_cmd_addr_interface;
	import ddrca_pkg::*;
	logic clk, srst, lclk, cke, cs_n, qs, dq_oe, lqs, lqs_oe, uqs, uqs_oe, refresh;
	logic [2:0] cmd;
	logic [1:0] ba, msk;
	logic [11:0] addr, bmode, emode;
	logic [15:0] mdq, dq_o;
	logic [31:0] rd_data;
	logic [3:0] bank_open;
	ddrca_wr_type wr;
	ddrca_rd_type rd;
	ddrca_pwr_type pwr;
	ddrca_wr_type wq[$];
	ddrca_rd_type rq[$];
	int err_total = 0;
	int comparisons = 0;
	int refs = 0;
	// ==========================================================
	// wire resolution of the two-way pins
	wire logic [15:0] dq_w = dq_oe ? dq_o : mdq;
	wire logic lqs_w = lqs_oe ? lqs : qs;
	wire logic uqs_w = uqs_oe ? uqs : qs;
	ddrca_ctrl_model i_ddrca_ctrl_model (.lclk_o(lclk), .cke_o(cke), .cs_n_o(cs_n),
		.cmd_o(cmd), .ba_o(ba), .addr_o(addr), .dq_o(mdq), .msk_o(msk), .qs_o(qs));
	ddrca_cmd_addr_if i_ddrca_cmd_addr_if (.core_clk_i(clk), .srst_i(srst),
		.diff_clock_true_i(lclk), .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(cmd[2]),
		.cas_n_i(cmd[1]), .we_n_i(cmd[0]), .bank_sel_0_i(ba[0]), .bank_sel_1_i(ba[1]),
		.addr_in_i(addr), .dq_i(dq_w), .dq_o(dq_o), .dq_oe_o(dq_oe), .write_mask_i(msk),
		.lower_lane_strobe_i(lqs_w), .lower_lane_strobe_o(lqs),
		.lower_lane_strobe_oe_o(lqs_oe), .upper_lane_strobe_i(uqs_w),
		.upper_lane_strobe_o(uqs), .upper_lane_strobe_oe_o(uqs_oe), .wr_o(wr), .rd_o(rd),
		.rd_data_i(rd_data), .refresh_o(refresh), .bank_open_o(bank_open),
		.power_state_o(pwr), .base_mode_o(bmode), .ext_mode_o(emode));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ==========================================================
	// array side: read words carry their own column numbers
	always @(posedge clk) begin
		if (wr.valid === 1'b1) wq.push_back(wr);
		if (rd.valid === 1'b1) begin
			rq.push_back(rd);
			rd_data <= {7'h55, rd.col[1], 7'h2A, rd.col[0]};
		end
		if (refresh === 1'b1) refs++;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic go(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
		input logic k);
		i_ddrca_ctrl_model.issue(c, b, a, 1'b0, k, 0);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_mode();
		chk(pwr, PWR_ACTIVE);
		chk({bank_open, bmode, emode, dq_oe}, {4'h0, MODE_RST, 12'h000, 1'b0});
		go(CMD_MODE, MR_SEL_BASE, {5'h00, CL_CODE_3, 1'b1, BL_CODE_4}, 1'b1);
		go(CMD_MODE, MR_SEL_EXT, 12'h001, 1'b1);
		go(CMD_MODE, 2'h2, 12'hFFF, 1'b1);
		chk(bmode, {5'h00, CL_CODE_3, 1'b1, BL_CODE_4});
		chk(emode, 12'h001);
		$display("mode test done");
	endtask
	task automatic t_act();
		i_ddrca_ctrl_model.issue(CMD_ACTIVATE, 2'h1, 12'hABC, 1'b1, 1'b1, 0);
		chk(bank_open, 4'h0);
		go(CMD_ACTIVATE, 2'h1, 12'hABC, 1'b1);
		go(CMD_ACTIVATE, 2'h3, 12'h123, 1'b1);
		chk(bank_open, 4'hA);
		$display("activate test done");
	endtask
	// interleaved burst of four from column 5, masks on both halves
	task automatic t_write();
		logic [15:0] d [4];
		logic [1:0] m [4];
		d = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
		m = '{2'h0, 2'h1, 2'h2, 2'h0};
		i_ddrca_ctrl_model.wd = d;
		i_ddrca_ctrl_model.wm = m;
		i_ddrca_ctrl_model.issue(CMD_WRITE, 2'h1, 12'h405, 1'b0, 1'b1, 2);
		repeat (4) @(posedge lclk);
		chk(wq.size(), 2);
		for (int i = 0; i < 2 && i < wq.size(); i++) begin
			chk({wq[i].ba, wq[i].row}, {2'h1, 12'hABC});
			chk(wq[i].col, {9'(5 ^ (2*i+1)), 9'(5 ^ (2*i))});
			chk(wq[i].data, {d[2*i+1], d[2*i]});
			chk(wq[i].byte_en, {~m[2*i+1], ~m[2*i]});
		end
		chk(bank_open, 4'h8);
		$display("write test done");
	endtask
	// sequential burst of two from column 3
	task automatic t_read();
		go(CMD_MODE, MR_SEL_BASE, {5'h00, CL_CODE_25, 1'b0, BL_CODE_2}, 1'b1);
		chk(bmode, {5'h00, CL_CODE_25, 1'b0, BL_CODE_2});
		go(CMD_READ, 2'h3, 12'h003, 1'b1);
		for (int i = 0; i < 20 && dq_oe !== 1'b1; i++) begin
			@(posedge lclk);
			#1;
		end
		#11;
		chk({dq_oe, lqs_oe, uqs_oe, dq_o, lqs, uqs}, {3'h7, 7'h2A, 9'h003, 2'h3});
		#24;
		chk({dq_oe, lqs_oe, uqs_oe, dq_o, lqs, uqs}, {3'h7, 7'h55, 9'h002, 2'h0});
		#24;
		chk({dq_oe, lqs_oe, uqs_oe}, 3'h0);
		chk(rq.size(), 1);
		if (rq.size() > 0) chk({rq[0].ba, rq[0].row, rq[0].col}, {14'h3123, 9'h2, 9'h3});
		chk(bank_open, 4'h8);
		$display("read test done");
	endtask
	task automatic t_pre();
		go(CMD_PRECHARGE, 2'h3, 12'h000, 1'b1);
		chk(bank_open, 4'h0);
		go(CMD_ACTIVATE, 2'h0, 12'h001, 1'b1);
		go(CMD_ACTIVATE, 2'h2, 12'h002, 1'b1);
		go(CMD_PRECHARGE, 2'h0, 12'hBFF, 1'b1);
		chk(bank_open, 4'h4);
		$display("precharge test done");
	endtask
	// sequential burst of eight from column 10 in open bank 2, cut after three pairs
	task automatic t_stop();
		int q0;
		go(CMD_MODE, MR_SEL_BASE, {5'h00, CL_CODE_2, 1'b0, BL_CODE_8}, 1'b1);
		q0 = rq.size();
		go(CMD_READ, 2'h2, 12'h00A, 1'b1);
		go(CMD_BURST_STOP, 2'h0, 12'h000, 1'b1);
		repeat (8) @(posedge lclk);
		chk(rq.size() - q0, 3);
		for (int i = 0; i < 3 && q0 + i < rq.size(); i++) begin
			chk({rq[q0+i].ba, rq[q0+i].row, rq[q0+i].col},
				{2'h2, 12'h002, 9'(11 + 2*i), 9'(10 + 2*i)});
		end
		chk({bmode[6:4], bank_open, dq_oe}, {CL_CODE_2, 4'h4, 1'b0});
		$display("burst stop test done");
	endtask
	task automatic t_power();
		int r0;
		go(3'h7, 2'h0, 12'h000, 1'b0);
		chk(pwr, PWR_PD_ACT);
		go(CMD_ACTIVATE, 2'h0, 12'h000, 1'b0);
		chk(bank_open, 4'h4);
		i_ddrca_ctrl_model.hold_cke(1'b1);
		repeat (2) @(posedge lclk);
		chk(pwr, PWR_ACTIVE);
		go(CMD_PRECHARGE, 2'h1, 12'h400, 1'b1);
		go(3'h7, 2'h0, 12'h000, 1'b0);
		chk({bank_open, pwr}, {4'h0, PWR_PD_PRE});
		i_ddrca_ctrl_model.hold_cke(1'b1);
		repeat (2) @(posedge lclk);
		r0 = refs;
		go(CMD_REFRESH, 2'h0, 12'h000, 1'b1);
		chk(refs - r0, 1);
		r0 = refs;
		go(CMD_REFRESH, 2'h0, 12'h000, 1'b0);
		chk(pwr, PWR_SELF);
		repeat (3200) @(posedge clk);
		chk(refs - r0, 2);
		i_ddrca_ctrl_model.hold_cke(1'b1);
		repeat (10) @(posedge clk);
		chk(pwr, PWR_ACTIVE);
		$display("power test done");
	endtask
	// ==========================================================
	// reset spans 8 link cycles so the link-side synchroniser clears too
	initial begin
		srst = 1'b1;
		repeat (8) @(posedge lclk);
		@(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge lclk);
		t_mode();
		t_act();
		t_write();
		t_read();
		t_pre();
		t_stop();
		t_power();
		results();
	end
	initial begin
		#100000;
		err_total++;
		results();
	end
endmodule
`default_nettype wire
